/* File: osc_ctrl.sv */
// Output safety controller with AXI4-Lite register access
//
// Design decisions made here: the address map and the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
`default_nettype none
module osc_ctrl
	import osc_pkg::*;
#(
	parameter int TICK_CYCLES = TICK_CYCLES_DEF,
	parameter int MWDT_CYCLES = MWDT_CYCLES_DEF
)(
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [11:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [11:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic [NCH-1:0] din,
	input wire logic init_strap_n,
	input wire logic nv_timeout_i,
	output logic [NCH-1:0] relay_out,
	output logic nv_timeout_wr,
	output logic nv_timeout_data,
	output logic recovery_mode
);
	function automatic logic [31:0] osc_merge(input logic [31:0] old, input logic [31:0] nw,
		input logic [3:0] strb);
		logic [31:0] m;
		m = old;
		for (int i = 0; i < 4; i++)
			if (strb[i])
				m[8*i +: 8] = nw[8*i +: 8];
		return m;
	endfunction

	// Bus slave state
	logic aw_hold_r, aw_hold_nxt, w_hold_r, w_hold_nxt;
	logic [11:0] aw_addr_r, aw_addr_nxt;
	logic [31:0] w_data_r, w_data_nxt;
	logic [3:0] w_strb_r, w_strb_nxt;
	logic awready_r, awready_nxt, wready_r, wready_nxt;
	logic bvalid_r, bvalid_nxt, arready_r, arready_nxt, rvalid_r, rvalid_nxt;
	logic [1:0] bresp_r, bresp_nxt, rresp_r, rresp_nxt;
	logic [31:0] rdata_r, rdata_nxt;
	logic wr_go, rd_go;
	// Control state
	osc_state_t state_r, state_nxt;
	logic strap_done_r, strap_done_nxt, recovery_r, recovery_nxt, proto_r, proto_nxt;
	logic timeout_r, timeout_nxt, reset_stat_r, reset_stat_nxt, fresh_r, fresh_nxt;
	logic nv_wr_r, nv_wr_nxt, nv_data_r, nv_data_nxt, hb_r, hb_nxt;
	logic [NCH-1:0] relay_r, relay_nxt, din_r, pon_r, pon_nxt, safe_r, safe_nxt;
	logic hwdt_en_r, hwdt_en_nxt;
	logic [15:0] hwdt_ms_r, hwdt_ms_nxt;
	osc_cfg_t cfg_r, cfg_nxt, stage_r, stage_nxt;
	logic [7:0] reply_char_r, reply_char_nxt, reply_data_r, reply_data_nxt;
	logic [31:0] reply_word_r, reply_word_nxt;
	osc_cmd_t cmd;
	logic [7:0] eff_addr;
	logic cmd_go, hit, is_write, wr_ok, hwdt_restart, hwdt_exp, mwdt_fire;
	logic [NCH-1:0] wr_val;

	always_comb
	begin
		wr_go = aw_hold_r && w_hold_r && !bvalid_r;
		rd_go = s_axi_arvalid && arready_r;
		aw_hold_nxt = aw_hold_r;
		aw_addr_nxt = aw_addr_r;
		w_hold_nxt = w_hold_r;
		w_data_nxt = w_data_r;
		w_strb_nxt = w_strb_r;
		bvalid_nxt = bvalid_r;
		bresp_nxt = bresp_r;
		rvalid_nxt = rvalid_r;
		rresp_nxt = rresp_r;
		rdata_nxt = rdata_r;
		if (s_axi_awvalid && awready_r)
		begin
			aw_hold_nxt = 1'b1;
			aw_addr_nxt = s_axi_awaddr;
		end
		if (s_axi_wvalid && wready_r)
		begin
			w_hold_nxt = 1'b1;
			w_data_nxt = s_axi_wdata;
			w_strb_nxt = s_axi_wstrb;
		end
		if (bvalid_r && s_axi_bready)
			bvalid_nxt = 1'b0;
		if (wr_go)
		begin
			aw_hold_nxt = 1'b0;
			w_hold_nxt = 1'b0;
			bvalid_nxt = 1'b1;
			bresp_nxt = (aw_addr_r <= REG_RDATA && aw_addr_r[1:0] == 2'b00) ?
				RESP_OKAY : RESP_SLVERR;
		end
		if (rvalid_r && s_axi_rready)
			rvalid_nxt = 1'b0;
		if (rd_go)
		begin
			rvalid_nxt = 1'b1;
			rresp_nxt = RESP_OKAY;
			case (s_axi_araddr)
				REG_CMD: rdata_nxt = '0;
				REG_STATUS: rdata_nxt = {16'h0000, timeout_r ? STATUS_TIMEOUT : STATUS_OK,
					4'h0, proto_r, recovery_r, reset_stat_r, timeout_r};
				REG_CFG_STAGE: rdata_nxt = stage_r;
				REG_CFG: rdata_nxt = cfg_r;
				REG_VALUES: rdata_nxt = {19'h0_0000, safe_r, 3'h0, pon_r};
				REG_HWDT: rdata_nxt = {15'h0000, hwdt_en_r, hwdt_ms_r};
				REG_IO: rdata_nxt = {19'h0_0000, din_r, 3'h0, relay_r};
				REG_REPLY: rdata_nxt = {15'h0000, fresh_r, reply_data_r, reply_char_r};
				REG_RDATA: rdata_nxt = reply_word_r;
				default:
				begin
					rdata_nxt = '0;
					rresp_nxt = RESP_SLVERR;
				end
			endcase
		end
		awready_nxt = !aw_hold_nxt;
		wready_nxt = !w_hold_nxt;
		arready_nxt = !rvalid_nxt;
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			aw_hold_r <= 1'b0;
			aw_addr_r <= '0;
			w_hold_r <= 1'b0;
			w_data_r <= '0;
			w_strb_r <= '0;
			awready_r <= 1'b0;
			wready_r <= 1'b0;
			bvalid_r <= 1'b0;
			bresp_r <= RESP_OKAY;
			arready_r <= 1'b0;
			rvalid_r <= 1'b0;
			rresp_r <= RESP_OKAY;
			rdata_r <= '0;
		end
		else
		begin
			aw_hold_r <= aw_hold_nxt;
			aw_addr_r <= aw_addr_nxt;
			w_hold_r <= w_hold_nxt;
			w_data_r <= w_data_nxt;
			w_strb_r <= w_strb_nxt;
			awready_r <= awready_nxt;
			wready_r <= wready_nxt;
			bvalid_r <= bvalid_nxt;
			bresp_r <= bresp_nxt;
			arready_r <= arready_nxt;
			rvalid_r <= rvalid_nxt;
			rresp_r <= rresp_nxt;
			rdata_r <= rdata_nxt;
		end
	end

	osc_host_wdt #(.TICK_CYCLES(TICK_CYCLES)) u_hwdt (
		.aclk(aclk),
		.aresetn(aresetn),
		.enable(hwdt_en_r && hwdt_ms_r != 16'h0000 && state_r == ST_RUN),
		.interval_ms(hwdt_ms_r),
		.restart(hwdt_restart),
		.expire(hwdt_exp)
	);

	osc_mod_wdt #(.CYCLES(MWDT_CYCLES)) u_mwdt (
		.aclk(aclk),
		.aresetn(aresetn),
		.heartbeat(hb_r),
		.fire(mwdt_fire)
	);

	always_comb
	begin
		cmd = osc_merge(32'h0000_0000, w_data_r, w_strb_r);
		eff_addr = recovery_r ? RECOVERY_ADDR : cfg_r.nn;
		cmd_go = wr_go && aw_addr_r == REG_CMD && state_r == ST_RUN;
		hit = cmd.addr == eff_addr;
		hwdt_restart = cmd_go && hit;
		is_write = cmd.op == OP_WRITE_ALL_OUTPUTS || cmd.op == OP_WRITE_OUTPUT_GROUP;
		wr_ok = 1'b0;
		wr_val = relay_r;
		if (cmd.op == OP_WRITE_ALL_OUTPUTS)
		begin
			wr_ok = cmd.p1[7:NCH] == '0;
			wr_val = cmd.p1[NCH-1:0];
		end
		else if (cmd.p2 == GRP_LOW || cmd.p2 == GRP_ALT)
		begin
			wr_ok = cmd.p1[7:NCH] == '0;
			wr_val = cmd.p1[NCH-1:0];
		end
		else if ((cmd.p2[7:4] == SGL_LOW || cmd.p2[7:4] == SGL_ALT) && cmd.p2[3:0] < 4'(NCH)
			&& (cmd.p1 == SGL_OFF || cmd.p1 == SGL_ON))
		begin
			wr_ok = 1'b1;
			wr_val[cmd.p2[2:0]] = cmd.p1[0];
		end
		state_nxt = state_r;
		strap_done_nxt = strap_done_r;
		recovery_nxt = recovery_r;
		proto_nxt = proto_r;
		timeout_nxt = timeout_r;
		reset_stat_nxt = reset_stat_r;
		relay_nxt = relay_r;
		pon_nxt = pon_r;
		safe_nxt = safe_r;
		hwdt_en_nxt = hwdt_en_r;
		hwdt_ms_nxt = hwdt_ms_r;
		cfg_nxt = cfg_r;
		stage_nxt = stage_r;
		reply_char_nxt = reply_char_r;
		reply_data_nxt = reply_data_r;
		reply_word_nxt = reply_word_r;
		fresh_nxt = fresh_r;
		nv_wr_nxt = 1'b0;
		nv_data_nxt = nv_data_r;
		hb_nxt = state_r == ST_RUN;
		if (rd_go && s_axi_araddr == REG_REPLY)
			fresh_nxt = 1'b0;
		if (wr_go)
			case (aw_addr_r)
				REG_CFG_STAGE: stage_nxt = osc_merge(stage_r, w_data_r, w_strb_r);
				REG_VALUES:
				begin
					if (w_strb_r[0])
						pon_nxt = w_data_r[NCH-1:0];
					if (w_strb_r[1])
						safe_nxt = w_data_r[HI_LSB +: NCH];
				end
				REG_HWDT:
				begin
					hwdt_ms_nxt = 16'(osc_merge({16'h0000, hwdt_ms_r}, w_data_r, w_strb_r));
					if (w_strb_r[2])
						hwdt_en_nxt = w_data_r[HWDT_EN_BIT];
				end
				default: ;
			endcase
		if (state_r == ST_BOOT)
		begin
			if (!strap_done_r)
			begin
				strap_done_nxt = 1'b1;
				recovery_nxt = !init_strap_n;
			end
			timeout_nxt = nv_timeout_i;
			relay_nxt = nv_timeout_i ? safe_r : pon_r;
			reset_stat_nxt = 1'b1;
			state_nxt = ST_RUN;
		end
		else if (cmd_go && hit)
		begin
			fresh_nxt = 1'b1;
			reply_char_nxt = RPL_VALID;
			reply_data_nxt = STATUS_OK;
			case (cmd.op)
				OP_READ_MODULE_STATUS:
					reply_data_nxt = timeout_r ? STATUS_TIMEOUT : STATUS_OK;
				OP_CLEAR_TIMEOUT:
				begin
					timeout_nxt = 1'b0;
					nv_wr_nxt = 1'b1;
					nv_data_nxt = 1'b0;
				end
				OP_READ_RESET_STATUS:
				begin
					reply_data_nxt = {7'h00, reset_stat_r};
					reset_stat_nxt = 1'b0;
				end
				OP_SET_CONFIGURATION:
					if (stage_r.tt != TYPE_DIO || (!recovery_r && (stage_r.cc != cfg_r.cc
						|| stage_r.ff[FMT_CKSUM_BIT] != cfg_r.ff[FMT_CKSUM_BIT])))
						reply_char_nxt = RPL_BAD;
					else
					begin
						cfg_nxt = stage_r;
						reply_data_nxt = stage_r.nn;
					end
				OP_PROTOCOL_SELECT:
					if (recovery_r)
						proto_nxt = cmd.p1[0];
					else
						reply_char_nxt = RPL_BAD;
				OP_WRITE_ALL_OUTPUTS, OP_WRITE_OUTPUT_GROUP:
					if (!wr_ok)
						reply_char_nxt = RPL_BAD;
					else if (!timeout_r)
					begin
						relay_nxt = wr_val;
						reply_char_nxt = RPL_DONE;
					end
				OP_READ_CONFIGURATION:
				begin
					reply_word_nxt = cfg_r;
					reply_data_nxt = cfg_r.nn;
				end
				default: reply_char_nxt = RPL_BAD;
			endcase
		end
		if (hwdt_exp)
		begin
			timeout_nxt = 1'b1;
			relay_nxt = safe_r;
			nv_wr_nxt = 1'b1;
			nv_data_nxt = 1'b1;
		end
		if (mwdt_fire)
			state_nxt = ST_BOOT;
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			state_r <= ST_BOOT;
			strap_done_r <= 1'b0;
			recovery_r <= 1'b0;
			proto_r <= 1'b0;
			timeout_r <= 1'b0;
			reset_stat_r <= 1'b1;
			relay_r <= PON_RST;
			din_r <= '0;
			pon_r <= PON_RST;
			safe_r <= SAFE_RST;
			hwdt_en_r <= 1'b0;
			hwdt_ms_r <= HWDT_MS_RST;
			cfg_r <= {DEF_FMT, BAUD_9600, TYPE_DIO, DEF_ADDR};
			stage_r <= {DEF_FMT, BAUD_9600, TYPE_DIO, DEF_ADDR};
			reply_char_r <= RPL_VALID;
			reply_data_r <= STATUS_OK;
			reply_word_r <= '0;
			fresh_r <= 1'b0;
			nv_wr_r <= 1'b0;
			nv_data_r <= 1'b0;
			hb_r <= 1'b0;
		end
		else
		begin
			state_r <= state_nxt;
			strap_done_r <= strap_done_nxt;
			recovery_r <= recovery_nxt;
			proto_r <= proto_nxt;
			timeout_r <= timeout_nxt;
			reset_stat_r <= reset_stat_nxt;
			relay_r <= relay_nxt;
			din_r <= din;
			pon_r <= pon_nxt;
			safe_r <= safe_nxt;
			hwdt_en_r <= hwdt_en_nxt;
			hwdt_ms_r <= hwdt_ms_nxt;
			cfg_r <= cfg_nxt;
			stage_r <= stage_nxt;
			reply_char_r <= reply_char_nxt;
			reply_data_r <= reply_data_nxt;
			reply_word_r <= reply_word_nxt;
			fresh_r <= fresh_nxt;
			nv_wr_r <= nv_wr_nxt;
			nv_data_r <= nv_data_nxt;
			hb_r <= hb_nxt;
		end
	end

	assign s_axi_awready = awready_r;
	assign s_axi_wready = wready_r;
	assign s_axi_bvalid = bvalid_r;
	assign s_axi_bresp = bresp_r;
	assign s_axi_arready = arready_r;
	assign s_axi_rvalid = rvalid_r;
	assign s_axi_rresp = rresp_r;
	assign s_axi_rdata = rdata_r;
	assign relay_out = relay_r;
	assign nv_timeout_wr = nv_wr_r;
	assign nv_timeout_data = nv_data_r;
	assign recovery_mode = recovery_r;

	default clocking @(posedge aclk); endclocking
	default disable iff (!aresetn);
	sequence expire_s;
		hwdt_exp && !mwdt_fire;
	endsequence
	sequence cmd_s(osc_op_t op);
		cmd_go && hit && cmd.op == op && !hwdt_exp && !mwdt_fire;
	endsequence
	timeout_safe_a: assert property (expire_s |=> timeout_r && relay_out == $past(safe_r))
		else $error("outputs not safe after host timeout");
	nv_store_a: assert property (expire_s |=> nv_timeout_wr && nv_timeout_data)
		else $error("timeout flag not stored");
	timeout_hold_a: assert property (timeout_r && state_r == ST_RUN
		&& !(cmd_go && hit && cmd.op == OP_CLEAR_TIMEOUT) |=> timeout_r)
		else $error("timeout flag cleared without command");
	ignore_write_a: assert property (cmd_go && hit && is_write && timeout_r && !hwdt_exp
		&& !mwdt_fire |=> relay_out == $past(relay_out) && reply_char_r != RPL_DONE)
		else $error("output write not ignored while timed out");
	status_code_a: assert property (cmd_s(OP_READ_MODULE_STATUS) ##0 timeout_r
		|=> reply_data_r == STATUS_TIMEOUT)
		else $error("status code not 04 while timed out");
	reset_read_a: assert property (cmd_s(OP_READ_RESET_STATUS) |=> !reset_stat_r [*2])
		else $error("reset status not cleared by read");
	boot_value_a: assert property (state_r == ST_BOOT && !hwdt_exp
		|=> reset_stat_r && relay_out == ($past(nv_timeout_i) ? $past(safe_r) : $past(pon_r)))
		else $error("wrong output value after reset");
	write_ok_a: assert property (cmd_go && hit && is_write && wr_ok && !timeout_r && !hwdt_exp
		&& !mwdt_fire |=> relay_out == $past(wr_val) && reply_char_r == RPL_DONE)
		else $error("accepted output write not applied");
	recovery_addr_a: assert property (recovery_r |-> eff_addr == RECOVERY_ADDR)
		else $error("recovery address not 00");
	mwdt_boot_a: assert property (mwdt_fire |=> state_r == ST_BOOT ##1 reset_stat_r)
		else $error("module watchdog did not restart");
endmodule
`default_nettype wire

/* File: osc_pkg.sv */
// Constants, types and command codes of the output safety controller
// Summary of operation
// - Five relay outputs are driven and five isolated inputs are sampled.
// - Shipped settings are address 01, type code 40 and a rate of 9600 bit/s.
// - With the recovery strap active at power-up, address 00, 9600 bit/s, no checksum apply; the code forces only address 00.
// - In recovery mode the read-configuration command returns the stored configuration.
// - Rate or checksum changes and protocol selection are accepted only in recovery mode.
// - After power-on or module-watchdog reset outputs take the power-on value if no timeout.
// - Expiry of the host watchdog sets the timeout flag and drives outputs to the safe value.
// - While timed out, the read-module-status command reports status code 04.
// - While timed out, output writes are dropped, outputs hold, and the ignore reply returns.
// - The timeout flag is stored on setting and cleared only by the clear-timeout command.
// - The reset-status flag sets on power-up or module-watchdog reset and clears when read.
// - With no timeout, an output command updates the outputs and returns the success reply.
// - An independent module watchdog resets the module when its operation halts.
package osc_pkg;
	localparam int CLK_PERIOD_NS = 50;
	localparam int MS_NS = 1000000;
	localparam int TICK_CYCLES_DEF = MS_NS / CLK_PERIOD_NS;
	localparam int MWDT_TIMEOUT_MS = 100;
	localparam int MWDT_CYCLES_DEF = MWDT_TIMEOUT_MS * (MS_NS / CLK_PERIOD_NS);
	localparam int NCH = 5;
	localparam logic [7:0] DEF_ADDR = 8'h01;
	localparam logic [7:0] TYPE_DIO = 8'h40;
	localparam logic [7:0] BAUD_9600 = 8'h06;
	localparam logic [7:0] DEF_FMT = 8'h00;
	localparam logic [7:0] RECOVERY_ADDR = 8'h00;
	localparam int FMT_CKSUM_BIT = 6;
	localparam logic [7:0] STATUS_TIMEOUT = 8'h04;
	localparam logic [7:0] STATUS_OK = 8'h00;
	localparam logic [7:0] RPL_VALID = 8'h21;
	localparam logic [7:0] RPL_DONE = 8'h3E;
	localparam logic [7:0] RPL_BAD = 8'h3F;
	localparam logic [7:0] GRP_LOW = 8'h00;
	localparam logic [7:0] GRP_ALT = 8'h0A;
	localparam logic [3:0] SGL_LOW = 4'h1;
	localparam logic [3:0] SGL_ALT = 4'hA;
	localparam logic [7:0] SGL_OFF = 8'h00;
	localparam logic [7:0] SGL_ON = 8'h01;
	localparam logic [11:0] REG_CMD = 12'h000;
	localparam logic [11:0] REG_STATUS = 12'h004;
	localparam logic [11:0] REG_CFG_STAGE = 12'h008;
	localparam logic [11:0] REG_CFG = 12'h00C;
	localparam logic [11:0] REG_VALUES = 12'h010;
	localparam logic [11:0] REG_HWDT = 12'h014;
	localparam logic [11:0] REG_IO = 12'h018;
	localparam logic [11:0] REG_REPLY = 12'h01C;
	localparam logic [11:0] REG_RDATA = 12'h020;
	localparam int HI_LSB = 8;
	localparam int HWDT_EN_BIT = 16;
	localparam int FRESH_BIT = 16;
	localparam logic [4:0] PON_RST = 5'h00;
	localparam logic [4:0] SAFE_RST = 5'h00;
	localparam logic [15:0] HWDT_MS_RST = 16'h0064;
	localparam logic [1:0] RESP_OKAY = 2'b00;
	localparam logic [1:0] RESP_SLVERR = 2'b10;
	typedef enum logic [3:0] {
		OP_NONE = 4'h0,
		OP_READ_MODULE_STATUS = 4'h1,
		OP_CLEAR_TIMEOUT = 4'h2,
		OP_READ_RESET_STATUS = 4'h3,
		OP_SET_CONFIGURATION = 4'h4,
		OP_PROTOCOL_SELECT = 4'h5,
		OP_WRITE_ALL_OUTPUTS = 4'h6,
		OP_WRITE_OUTPUT_GROUP = 4'h7,
		OP_READ_CONFIGURATION = 4'h8
	} osc_op_t;
	typedef struct packed {
		logic [7:0] p2;
		logic [7:0] p1;
		logic [7:0] addr;
		logic [3:0] pad;
		osc_op_t op;
	} osc_cmd_t;
	typedef struct packed {
		logic [7:0] ff;
		logic [7:0] cc;
		logic [7:0] tt;
		logic [7:0] nn;
	} osc_cfg_t;
	typedef enum logic [1:0] {ST_BOOT = 2'b00, ST_RUN = 2'b01} osc_state_t;
endpackage

/* File: osc_host_wdt.sv */
// Host watchdog interval timer with millisecond tick
`timescale 1ns/1ps
`default_nettype none
module osc_host_wdt
	import osc_pkg::*;
#(
	parameter int TICK_CYCLES = TICK_CYCLES_DEF
)(
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic enable,
	input wire logic [15:0] interval_ms,
	input wire logic restart,
	output logic expire
);
	logic [31:0] tick_r, tick_nxt;
	logic [15:0] ms_r, ms_nxt;
	logic armed_r, armed_nxt, exp_r, exp_nxt;
	always_comb
	begin
		tick_nxt = tick_r;
		ms_nxt = ms_r;
		armed_nxt = armed_r;
		exp_nxt = 1'b0;
		if (restart || !enable)
		begin
			tick_nxt = '0;
			ms_nxt = '0;
			armed_nxt = 1'b1;
		end
		else if (armed_r)
		begin
			if (tick_r == 32'(TICK_CYCLES - 1))
			begin
				tick_nxt = '0;
				ms_nxt = ms_r + 16'h0001;
				if (ms_nxt >= interval_ms)
				begin
					exp_nxt = 1'b1;
					armed_nxt = 1'b0;
				end
			end
			else
				tick_nxt = tick_r + 32'h0000_0001;
		end
	end
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			tick_r <= '0;
			ms_r <= '0;
			armed_r <= 1'b1;
			exp_r <= 1'b0;
		end
		else
		begin
			tick_r <= tick_nxt;
			ms_r <= ms_nxt;
			armed_r <= armed_nxt;
			exp_r <= exp_nxt;
		end
	end
	assign expire = exp_r;
endmodule
`default_nettype wire

/* File: osc_mod_wdt.sv */
// Module watchdog fed by a heartbeat from the control logic
`timescale 1ns/1ps
`default_nettype none
module osc_mod_wdt
	import osc_pkg::*;
#(
	parameter int CYCLES = MWDT_CYCLES_DEF
)(
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic heartbeat,
	output logic fire
);
	logic [31:0] cnt_r, cnt_nxt;
	logic fire_r, fire_nxt;
	always_comb
	begin
		cnt_nxt = cnt_r + 32'h0000_0001;
		fire_nxt = 1'b0;
		if (heartbeat)
			cnt_nxt = '0;
		else if (cnt_r == 32'(CYCLES - 1))
		begin
			cnt_nxt = '0;
			fire_nxt = 1'b1;
		end
	end
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			cnt_r <= '0;
			fire_r <= 1'b0;
		end
		else
		begin
			cnt_r <= cnt_nxt;
			fire_r <= fire_nxt;
		end
	end
	assign fire = fire_r;
endmodule
`default_nettype wire

/* File: osc_nv_model.sv */
// Nonvolatile storage model holding the host-timeout flag
`timescale 1ns/1ps
`default_nettype none
module osc_nv_model (
	input wire logic aclk,
	input wire logic wr,
	input wire logic data,
	output var logic flag
);
	// Survives every module reset
	initial flag = 1'b0;
	always @(posedge aclk)
	begin
		if (wr)
			flag <= data;
	end
endmodule
`default_nettype wire

/* File: tb.sv */
// Self-checking bench for the output safety controller
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, e) begin samples_checked++; if ((a) !== (e)) begin n_fail++; \
	$display("MISMATCH t=%0t got=%h exp=%h", $time, (a), (e)); end end
module tb
	import osc_pkg::*;
;
	typedef struct packed {
		osc_op_t op;
		logic [7:0] p1;
		logic [7:0] p2;
		logic [7:0] reply;
		logic [NCH-1:0] relay;
	} osc_row_t;
	logic aclk = 1'b0;
	logic aresetn = 1'b0;
	logic [11:0] awaddr = '0;
	logic [11:0] araddr = '0;
	logic [31:0] wdata = '0;
	logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
	logic [NCH-1:0] din = '0;
	logic strap_n = 1'b1;
	logic awready, wready, bvalid, arready, rvalid, nv_i, nv_wr, nv_d, recovery;
	logic [1:0] bresp, rresp, rsp;
	logic [31:0] rdata, rd_v;
	logic [NCH-1:0] relay;
	int n_fail = 0;
	int samples_checked = 0;
	int nv_pulses = 0;
	osc_row_t rows [6] = '{
		'{OP_WRITE_ALL_OUTPUTS, 8'h15, 8'h00, RPL_DONE, 5'h15},
		'{OP_WRITE_OUTPUT_GROUP, 8'h0A, GRP_ALT, RPL_DONE, 5'h0A},
		'{OP_WRITE_OUTPUT_GROUP, SGL_ON, {SGL_LOW, 4'h2}, RPL_DONE, 5'h0E},
		'{OP_WRITE_OUTPUT_GROUP, SGL_OFF, {SGL_ALT, 4'h1}, RPL_DONE, 5'h0C},
		'{OP_WRITE_OUTPUT_GROUP, SGL_ON, {SGL_LOW, 4'h5}, RPL_BAD, 5'h0C},
		'{OP_WRITE_OUTPUT_GROUP, 8'h20, GRP_LOW, RPL_BAD, 5'h0C}
	};

	osc_ctrl #(
		.TICK_CYCLES(4),
		.MWDT_CYCLES(64)
	) dut_u (
		.aclk(aclk), .aresetn(aresetn),
		.s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
		.s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
		.s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
		.s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
		.s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
		.din(din), .init_strap_n(strap_n), .nv_timeout_i(nv_i), .relay_out(relay),
		.nv_timeout_wr(nv_wr), .nv_timeout_data(nv_d), .recovery_mode(recovery)
	);
	osc_nv_model nv_u (.aclk(aclk), .wr(nv_wr), .data(nv_d), .flag(nv_i));

	initial
	begin
		forever #25 aclk = ~aclk;
	end
	initial
	begin
		#1000000;
		n_fail++;
		results();
	end
	always @(posedge aclk)
	begin
		if (nv_wr)
			nv_pulses++;
	end

	task automatic results();
		$display("checks=%0d fails=%0d", samples_checked, n_fail);
		if (n_fail == 0 && samples_checked > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask

	task automatic do_reset(input logic strap);
		@(posedge aclk);
		aresetn <= 1'b0;
		strap_n <= strap;
		repeat (4) @(posedge aclk);
		aresetn <= 1'b1;
		repeat (2) @(posedge aclk);
	endtask

	task automatic wr(input logic [11:0] a, input logic [31:0] d, output logic [1:0] r);
		int n;
		n = 0;
		@(posedge aclk);
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		do
		begin
			@(posedge aclk);
			n++;
			if (awready)
				awvalid <= 1'b0;
			if (wready)
				wvalid <= 1'b0;
		end
		while (!bvalid && n < 40);
		r = bresp;
		bready <= 1'b0;
		if (n >= 40)
			n_fail++;
	endtask

	task automatic rd(input logic [11:0] a, output logic [31:0] d, output logic [1:0] r);
		int n;
		n = 0;
		@(posedge aclk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		do
		begin
			@(posedge aclk);
			n++;
			if (arready)
				arvalid <= 1'b0;
		end
		while (!rvalid && n < 40);
		d = rdata;
		r = rresp;
		rready <= 1'b0;
		if (n >= 40)
			n_fail++;
	endtask

	// Command write, then reply register into rd_v
	task automatic cmd(input osc_op_t op, input logic [7:0] ad, input logic [7:0] p1,
		input logic [7:0] p2);
		wr(REG_CMD, {p2, p1, ad, 4'h0, op}, rsp);
		rd(REG_REPLY, rd_v, rsp);
	endtask

	initial
	begin
		do_reset(1'b1);
		`CHK(relay, PON_RST)
		`CHK(recovery, 1'b0)
		rd(REG_STATUS, rd_v, rsp);
		`CHK(rd_v[1:0], 2'b10)
		rd(REG_CFG, rd_v, rsp);
		`CHK(rd_v, {DEF_FMT, BAUD_9600, TYPE_DIO, DEF_ADDR})
		cmd(OP_READ_RESET_STATUS, DEF_ADDR, 8'h00, 8'h00);
		`CHK(rd_v[15:8], 8'h01)
		rd(REG_STATUS, rd_v, rsp);
		`CHK(rd_v[1], 1'b0)
		din <= 5'h13;
		foreach (rows[i])
		begin
			cmd(rows[i].op, DEF_ADDR, rows[i].p1, rows[i].p2);
			`CHK(rd_v[7:0], rows[i].reply)
			`CHK(relay, rows[i].relay)
		end
		rd(REG_IO, rd_v, rsp);
		`CHK(rd_v[12:0], {5'h13, 3'b000, 5'h0C})
		wr(12'h024, 32'h0000_0000, rsp);
		`CHK(rsp, RESP_SLVERR)
		rd(12'h030, rd_v, rsp);
		`CHK(rsp, RESP_SLVERR)
		wr(REG_CFG_STAGE, 32'h0007_4001, rsp);
		cmd(OP_SET_CONFIGURATION, DEF_ADDR, 8'h00, 8'h00);
		`CHK(rd_v[7:0], RPL_BAD)
		cmd(OP_PROTOCOL_SELECT, DEF_ADDR, 8'h01, 8'h00);
		`CHK(rd_v[7:0], RPL_BAD)
		wr(REG_VALUES, 32'h0000_0B06, rsp);
		wr(REG_HWDT, 32'h0001_0004, rsp);
		repeat (8) cmd(OP_READ_MODULE_STATUS, DEF_ADDR, 8'h00, 8'h00);
		`CHK(nv_pulses, 0)
		for (int k = 0; k < 60 && nv_i !== 1'b1; k++)
			@(posedge aclk);
		`CHK(relay, 5'h0B)
		`CHK(nv_i, 1'b1)
		`CHK(nv_pulses, 1)
		rd(REG_STATUS, rd_v, rsp);
		`CHK({rd_v[15:8], rd_v[0]}, {STATUS_TIMEOUT, 1'b1})
		cmd(OP_READ_MODULE_STATUS, DEF_ADDR, 8'h00, 8'h00);
		`CHK(rd_v[15:8], STATUS_TIMEOUT)
		cmd(OP_WRITE_ALL_OUTPUTS, DEF_ADDR, 8'h1F, 8'h00);
		`CHK(rd_v[7:0], RPL_VALID)
		`CHK(relay, 5'h0B)
		wr(REG_HWDT, 32'h0000_0004, rsp);
		cmd(OP_CLEAR_TIMEOUT, DEF_ADDR, 8'h00, 8'h00);
		`CHK(nv_i, 1'b0)
		cmd(OP_WRITE_ALL_OUTPUTS, DEF_ADDR, 8'h1F, 8'h00);
		`CHK(relay, 5'h1F)
		wr(REG_HWDT, 32'h0001_0004, rsp);
		for (int k = 0; k < 60 && nv_i !== 1'b1; k++)
			@(posedge aclk);
		`CHK(relay, 5'h0B)
		do_reset(1'b1);
		rd(REG_STATUS, rd_v, rsp);
		`CHK(rd_v[1:0], 2'b11)
		`CHK(relay, SAFE_RST)
		cmd(OP_CLEAR_TIMEOUT, DEF_ADDR, 8'h00, 8'h00);
		do_reset(1'b0);
		`CHK(recovery, 1'b1)
		`CHK(relay, PON_RST)
		cmd(OP_READ_MODULE_STATUS, DEF_ADDR, 8'h00, 8'h00);
		`CHK(rd_v[FRESH_BIT], 1'b0)
		cmd(OP_READ_CONFIGURATION, RECOVERY_ADDR, 8'h00, 8'h00);
		`CHK(rd_v[FRESH_BIT], 1'b1)
		rd(REG_RDATA, rd_v, rsp);
		`CHK(rd_v, {DEF_FMT, BAUD_9600, TYPE_DIO, DEF_ADDR})
		wr(REG_CFG_STAGE, 32'h0007_4000, rsp);
		cmd(OP_SET_CONFIGURATION, RECOVERY_ADDR, 8'h00, 8'h00);
		`CHK(rd_v[15:0], {8'h00, RPL_VALID})
		rd(REG_CFG, rd_v, rsp);
		`CHK(rd_v, 32'h0007_4000)
		results();
	end
endmodule
`default_nettype wire
